//--- src/fsp_pkg.sv
package fsp_pkg;

  // ------------------------------------------------------------
  // Register word addresses, first port
  // ------------------------------------------------------------
  localparam logic [23:0] ADDR_GLOBAL = 24'h808040;
  localparam logic [23:0] ADDR_TX_PIN = 24'h808042;
  localparam logic [23:0] ADDR_RX_PIN = 24'h808043;
  localparam logic [23:0] ADDR_TIM_CTL = 24'h808044;
  localparam logic [23:0] ADDR_TIM_CNT = 24'h808045;
  localparam logic [23:0] ADDR_TIM_PER = 24'h808046;
  localparam logic [23:0] ADDR_TX_DATA = 24'h808048;
  localparam logic [23:0] ADDR_RX_DATA = 24'h80804C;
  localparam logic [23:0] PORT_STRIDE = 24'h000010;
  localparam logic [23:0] PORT_SPAN_MASK = 24'hFFFFF0;

  // ------------------------------------------------------------
  // Global control fields
  // ------------------------------------------------------------
  localparam int BIT_RX_READY = 0;
  localparam int BIT_TX_FREE = 1;
  localparam int BIT_FSX_DIR = 2;
  localparam int BIT_TX_CLK_INT = 6;
  localparam int BIT_RX_CLK_INT = 7;
  localparam int BIT_TX_CONT = 10;
  localparam int BIT_RX_CONT = 11;
  localparam int LSB_TX_LEN = 18;
  localparam int LSB_RX_LEN = 20;
  localparam logic [31:0] GLOBAL_WR_MASK = 32'h003C0CC4;
  localparam logic [31:0] GLOBAL_RST = 32'h00000002;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int READY_DELAY = 3;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {
    FSP_TX_IDLE = 3'b001,
    FSP_TX_SYNC = 3'b010,
    FSP_TX_SHIFT = 3'b100
  } fsp_tx_state_t;

endpackage

//--- src/fsp_fifo.sv
`timescale 1ns/1ps
module fsp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rp_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage has no reset; words are only read when counted in
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule

//--- src/fsp_sync.sv
`timescale 1ns/1ps
module fsp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins in, filtered levels and rising and falling edges out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, nxt_lvl;

  // Change counts only when stages two and three agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
    end
  end

  assign level = lvl_ff;
  assign rise = nxt_lvl & ~lvl_ff;
  assign fall = ~nxt_lvl & lvl_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end
endmodule

//--- src/fsp_port.sv
`timescale 1ns/1ps
//
// Contract
// - Words are 8, 16, 24 or 32 bits and both directions run at once.
// - The bit clock comes from the port timer or from the clock pins.
// - The internal bit clock divides down the core output clock.
// - Continuous mode moves back-to-back words after one frame sync.
// - The port has eight registers: global, two pin, three timer, tx, rx.
// - Port 0 sits at 808040h, port 1 mirrors it at 808050h, rest reserved.
// - Tx buffer holds the next word out, rx buffer the last word in.
// - The global control register is 32 bits of mode and status.
// - Receive ready bit 0 sets three cycles after the rx buffer loads.
// - A rising receive ready raises the receive interrupt.
// - Receive ready resets to 0 and clears on an rx buffer read.
// - Bit 2 makes the tx frame sync pin an output when 1, resets to 0.
module fsp_port #(
  parameter logic [23:0] BASE = fsp_pkg::ADDR_GLOBAL,
  parameter bit TWO_PORTS = 1'b1,
  parameter int DEPTH = fsp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Peripheral bus
  input wire logic [23:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata,
  // Interrupts
  output logic receive_irq,
  output logic transmit_irq,
  // Serial pins
  output logic serial_out_pin,
  output logic serial_out_oe,
  input wire logic serial_in_pin,
  input wire logic tx_frame_sync_pin_in,
  output logic tx_frame_sync_pin_out,
  output logic tx_frame_sync_pin_oe,
  input wire logic rx_frame_sync_pin,
  input wire logic tx_bit_clock_pin_in,
  output logic tx_bit_clock_pin_out,
  output logic tx_bit_clock_pin_oe,
  input wire logic rx_bit_clock_pin_in,
  output logic rx_bit_clock_pin_out,
  output logic rx_bit_clock_pin_oe
);
  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  function automatic logic [5:0] bits_of(input logic [1:0] len);
    bits_of = {len, 3'b000} + 6'd8;
  endfunction
  function automatic logic hit(input logic [23:0] a, input logic [23:0] o);
    logic [23:0] p1;
    p1 = o + fsp_pkg::PORT_STRIDE;
    hit = (a == o) || (TWO_PORTS && (a == p1));
  endfunction
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] glob_ff, nxt_glob, txpc_ff, nxt_txpc, rxpc_ff, nxt_rxpc;
  logic [31:0] tctl_ff, nxt_tctl, tcnt_ff, nxt_tcnt, tper_ff, nxt_tper;
  logic [31:0] txd_ff, nxt_txd, rxd_ff, nxt_rxd, rdata_ff, nxt_rdata;
  logic [2:0] rdly_ff, nxt_rdly, xdly_ff, nxt_xdly;
  logic rirq_ff, nxt_rirq, xirq_ff, nxt_xirq, txfull_ff, nxt_txfull;
  logic wr_tx, rd_rx, rx_load, tx_take;
  logic [31:0] rx_word;
  assign wr_tx = wr_en && hit(addr, BASE + 24'h000008);
  assign rd_rx = rd_en && hit(addr, BASE + 24'h00000C);
  always_comb begin
    nxt_glob = glob_ff;
    nxt_txpc = txpc_ff;
    nxt_rxpc = rxpc_ff;
    nxt_tctl = tctl_ff;
    nxt_tper = tper_ff;
    nxt_txd = txd_ff;
    nxt_rxd = rxd_ff;
    nxt_txfull = txfull_ff;
    nxt_rdata = 32'h00000000;
    if (wr_en && hit(addr, BASE)) begin
      // Status bits keep their hardware value
      nxt_glob = (wdata & fsp_pkg::GLOBAL_WR_MASK) |
        (glob_ff & ~fsp_pkg::GLOBAL_WR_MASK);
    end
    if (wr_en && hit(addr, BASE + 24'h000002)) nxt_txpc = wdata;
    if (wr_en && hit(addr, BASE + 24'h000003)) nxt_rxpc = wdata;
    if (wr_en && hit(addr, BASE + 24'h000004)) nxt_tctl = wdata;
    if (wr_en && hit(addr, BASE + 24'h000006)) nxt_tper = wdata;
    if (tx_take) nxt_txfull = 1'b0;
    if (wr_tx) begin
      nxt_txd = wdata;
      nxt_txfull = 1'b1;
    end
    if (rx_load) nxt_rxd = rx_word;
    // Ready flags: a new event outranks the clearing access
    nxt_glob[fsp_pkg::BIT_RX_READY] = (rdly_ff == 3'd1) ||
      (glob_ff[fsp_pkg::BIT_RX_READY] && !rd_rx);
    nxt_glob[fsp_pkg::BIT_TX_FREE] = (xdly_ff == 3'd1) ||
      (glob_ff[fsp_pkg::BIT_TX_FREE] && !wr_tx);
    nxt_rdly = rx_load ? 3'(fsp_pkg::READY_DELAY) :
      (rdly_ff != 3'd0 ? rdly_ff - 3'd1 : 3'd0);
    nxt_xdly = tx_take ? 3'(fsp_pkg::READY_DELAY) :
      (xdly_ff != 3'd0 ? xdly_ff - 3'd1 : 3'd0);
    nxt_rirq = nxt_glob[fsp_pkg::BIT_RX_READY] &&
      !glob_ff[fsp_pkg::BIT_RX_READY];
    nxt_xirq = nxt_glob[fsp_pkg::BIT_TX_FREE] &&
      !glob_ff[fsp_pkg::BIT_TX_FREE];
    if (rd_en) begin
      if (hit(addr, BASE)) nxt_rdata = glob_ff;
      else if (hit(addr, BASE + 24'h000002)) nxt_rdata = txpc_ff;
      else if (hit(addr, BASE + 24'h000003)) nxt_rdata = rxpc_ff;
      else if (hit(addr, BASE + 24'h000004)) nxt_rdata = tctl_ff;
      else if (hit(addr, BASE + 24'h000005)) nxt_rdata = tcnt_ff;
      else if (hit(addr, BASE + 24'h000006)) nxt_rdata = tper_ff;
      else if (hit(addr, BASE + 24'h000008)) nxt_rdata = txd_ff;
      else if (hit(addr, BASE + 24'h00000C)) nxt_rdata = rxd_ff;
      else nxt_rdata = 32'h00000000;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      glob_ff <= fsp_pkg::GLOBAL_RST;
      txpc_ff <= '0;
      rxpc_ff <= '0;
      tctl_ff <= '0;
      tper_ff <= '0;
      txd_ff <= '0;
      rxd_ff <= '0;
      rdata_ff <= '0;
      rdly_ff <= '0;
      xdly_ff <= '0;
      rirq_ff <= 1'b0;
      xirq_ff <= 1'b0;
      txfull_ff <= 1'b0;
    end else begin
      glob_ff <= nxt_glob;
      txpc_ff <= nxt_txpc;
      rxpc_ff <= nxt_rxpc;
      tctl_ff <= nxt_tctl;
      tper_ff <= nxt_tper;
      txd_ff <= nxt_txd;
      rxd_ff <= nxt_rxd;
      rdata_ff <= nxt_rdata;
      rdly_ff <= nxt_rdly;
      xdly_ff <= nxt_xdly;
      rirq_ff <= nxt_rirq;
      xirq_ff <= nxt_xirq;
      txfull_ff <= nxt_txfull;
    end
  end
  assign rdata = rdata_ff;
  assign receive_irq = rirq_ff;
  assign transmit_irq = xirq_ff;
  // ------------------------------------------------------------
  // Bit clock timer
  // ------------------------------------------------------------
  // Toggles when the count meets the period, so rate is clk/(2(P+1))
  logic bclk_ff, nxt_bclk;
  always_comb begin
    nxt_tcnt = tcnt_ff + 32'd1;
    nxt_bclk = bclk_ff;
    if (tcnt_ff >= tper_ff) begin
      nxt_tcnt = 32'd0;
      nxt_bclk = ~bclk_ff;
    end
    if (wr_en && hit(addr, BASE + 24'h000005)) nxt_tcnt = wdata;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tcnt_ff <= '0;
      bclk_ff <= 1'b0;
    end else begin
      tcnt_ff <= nxt_tcnt;
      bclk_ff <= nxt_bclk;
    end
  end
  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  logic [4:0] pin_lvl, pin_rise, pin_fall;
  fsp_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({serial_in_pin, rx_frame_sync_pin, tx_frame_sync_pin_in,
      rx_bit_clock_pin_in, tx_bit_clock_pin_in}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  logic bclk_rise, bclk_fall, tx_edge, rx_edge;
  assign bclk_rise = nxt_bclk && !bclk_ff;
  assign bclk_fall = !nxt_bclk && bclk_ff;
  // Transmit changes data on the falling edge, receive samples on rising
  assign tx_edge = glob_ff[fsp_pkg::BIT_TX_CLK_INT] ? bclk_fall :
    pin_fall[0];
  assign rx_edge = glob_ff[fsp_pkg::BIT_RX_CLK_INT] ? bclk_rise :
    pin_rise[1];
  // ------------------------------------------------------------
  // Transmit path
  // ------------------------------------------------------------
  logic f_valid, f_ready, tx_pop;
  logic [31:0] f_data;
  fsp_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(txfull_ff),
    .in_ready(f_ready),
    .in_data(txd_ff),
    .out_valid(f_valid),
    .out_ready(tx_pop),
    .out_data(f_data)
  );
  assign tx_take = txfull_ff && f_ready;
  fsp_pkg::fsp_tx_state_t tst_ff, nxt_tst;
  logic [31:0] tsh_ff, nxt_tsh;
  logic [5:0] tcn_ff, nxt_tcn, tx_bits;
  logic tfs_ff, nxt_tfs, tfirst_ff, nxt_tfirst, ext_fsx;
  assign tx_bits = bits_of(glob_ff[fsp_pkg::LSB_TX_LEN +: 2]);
  assign ext_fsx = !glob_ff[fsp_pkg::BIT_FSX_DIR] && pin_lvl[2];
  always_comb begin
    nxt_tst = tst_ff;
    nxt_tsh = tsh_ff;
    nxt_tcn = tcn_ff;
    nxt_tfs = 1'b0;
    nxt_tfirst = tfirst_ff;
    tx_pop = 1'b0;
    unique case (tst_ff)
      fsp_pkg::FSP_TX_IDLE: begin
        if (!f_valid) nxt_tfirst = 1'b1;
        if (f_valid && tx_edge &&
            (glob_ff[fsp_pkg::BIT_FSX_DIR] || ext_fsx)) begin
          tx_pop = 1'b1;
          nxt_tsh = f_data << (6'd32 - tx_bits);
          nxt_tcn = tx_bits;
          nxt_tfs = glob_ff[fsp_pkg::BIT_FSX_DIR];
          nxt_tst = fsp_pkg::FSP_TX_SHIFT;
          // Continuous mode skips the sync after the first word
          if (glob_ff[fsp_pkg::BIT_TX_CONT] && !tfirst_ff) begin
            nxt_tfs = 1'b0;
          end
          nxt_tfirst = 1'b0;
        end
      end
      fsp_pkg::FSP_TX_SHIFT: begin
        if (tx_edge) begin
          nxt_tsh = {tsh_ff[30:0], 1'b0};
          nxt_tcn = tcn_ff - 6'd1;
          if (tcn_ff == 6'd1) begin
            nxt_tst = fsp_pkg::FSP_TX_IDLE;
            if (glob_ff[fsp_pkg::BIT_TX_CONT] && f_valid) begin
              tx_pop = 1'b1;
              nxt_tsh = f_data << (6'd32 - tx_bits);
              nxt_tcn = tx_bits;
              nxt_tst = fsp_pkg::FSP_TX_SHIFT;
            end
          end
        end
      end
      default: nxt_tst = fsp_pkg::FSP_TX_IDLE;
    endcase
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tst_ff <= fsp_pkg::FSP_TX_IDLE;
      tsh_ff <= '0;
      tcn_ff <= '0;
      tfs_ff <= 1'b0;
      tfirst_ff <= 1'b1;
    end else begin
      tst_ff <= nxt_tst;
      tsh_ff <= nxt_tsh;
      tcn_ff <= nxt_tcn;
      tfs_ff <= nxt_tfs;
      tfirst_ff <= nxt_tfirst;
    end
  end
  // ------------------------------------------------------------
  // Receive path
  // ------------------------------------------------------------
  logic [31:0] rsh_ff, nxt_rsh;
  logic [5:0] rcn_ff, nxt_rcn, rx_bits;
  logic ract_ff, nxt_ract, rload_ff, nxt_rload;
  assign rx_bits = bits_of(glob_ff[fsp_pkg::LSB_RX_LEN +: 2]);
  always_comb begin
    nxt_rsh = rsh_ff;
    nxt_rcn = rcn_ff;
    nxt_ract = ract_ff;
    nxt_rload = 1'b0;
    if (rx_edge) begin
      if (ract_ff) begin
        nxt_rsh = {rsh_ff[30:0], pin_lvl[4]};
        nxt_rcn = rcn_ff - 6'd1;
        if (rcn_ff == 6'd1) begin
          nxt_rload = 1'b1;
          nxt_rcn = rx_bits;
          // Continuous mode keeps receiving without a new sync
          nxt_ract = glob_ff[fsp_pkg::BIT_RX_CONT];
        end
      end else if (pin_lvl[3]) begin
        nxt_ract = 1'b1;
        nxt_rcn = rx_bits;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsh_ff <= '0;
      rcn_ff <= '0;
      ract_ff <= 1'b0;
      rload_ff <= 1'b0;
    end else begin
      rsh_ff <= nxt_rsh;
      rcn_ff <= nxt_rcn;
      ract_ff <= nxt_ract;
      rload_ff <= nxt_rload;
    end
  end
  assign rx_load = rload_ff;
  assign rx_word = rsh_ff & (32'hFFFFFFFF >> (6'd32 - rx_bits));
  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  assign serial_out_pin = tsh_ff[31];
  assign serial_out_oe = tst_ff[2];
  assign tx_frame_sync_pin_out = tfs_ff;
  assign tx_frame_sync_pin_oe = glob_ff[fsp_pkg::BIT_FSX_DIR];
  assign tx_bit_clock_pin_out = bclk_ff;
  assign tx_bit_clock_pin_oe = glob_ff[fsp_pkg::BIT_TX_CLK_INT];
  assign rx_bit_clock_pin_out = bclk_ff;
  assign rx_bit_clock_pin_oe = glob_ff[fsp_pkg::BIT_RX_CLK_INT];
endmodule

//--- dv/fsp_port_assertions.sv
`timescale 1ns/1ps
module fsp_port_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Peripheral bus
  input wire logic [23:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  // Outputs watched
  input wire logic receive_irq,
  input wire logic transmit_irq,
  input wire logic tx_frame_sync_pin_oe,
  input wire logic tx_bit_clock_pin_oe,
  input wire logic rx_bit_clock_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic wr_glb;
  logic wr_txd;
  logic rd_glb;
  logic rd_rsv;
  // Port 1 shares the register set, so its global writes count too
  assign wr_glb = wr_en && (addr == fsp_pkg::ADDR_GLOBAL ||
    addr == fsp_pkg::ADDR_GLOBAL + fsp_pkg::PORT_STRIDE);
  assign wr_txd = wr_en && addr == fsp_pkg::ADDR_TX_DATA;
  assign rd_glb = rd_en && addr == fsp_pkg::ADDR_GLOBAL;
  assign rd_rsv = rd_en && addr inside {24'h808041, 24'h808047,
    [24'h808049:24'h80804B], [24'h80804D:24'h80804F]};
  chk_rdata_idle: assert property (!rd_en |=> rdata == 32'h0)
    else $error("rdata not zero without a read");
  chk_reserved_zero: assert property (rd_rsv |=> rdata == 32'h0)
    else $error("reserved address read nonzero");
  chk_tx_ready_drop: assert property (wr_txd ##[1:2] rd_glb |=> !rdata[1])
    else $error("transmit ready high right after a data write");
  chk_fsx_dir: assert property (
    wr_glb |=> tx_frame_sync_pin_oe == $past(wdata[2]))
    else $error("frame sync direction does not follow bit 2");
  chk_fsx_hold: assert property (
    !wr_glb |=> $stable(tx_frame_sync_pin_oe))
    else $error("frame sync direction moved without a write");
  chk_txclk_sel: assert property (
    wr_glb |=> tx_bit_clock_pin_oe == $past(wdata[6]))
    else $error("tx clock source does not follow bit 6");
  chk_rxclk_sel: assert property (
    wr_glb |=> rx_bit_clock_pin_oe == $past(wdata[7]))
    else $error("rx clock source does not follow bit 7");
  chk_rx_irq_pulse: assert property (receive_irq |=> !receive_irq)
    else $error("receive interrupt longer than one cycle");
  chk_tx_irq_pulse: assert property (transmit_irq |=> !transmit_irq)
    else $error("transmit interrupt longer than one cycle");
  cover property (receive_irq);
  cover property (transmit_irq);
  cover property (wr_glb && wdata[2]);
endmodule

bind fsp_port fsp_port_assertions i_chk (
  .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
  .wdata(wdata), .rdata(rdata), .receive_irq(receive_irq),
  .transmit_irq(transmit_irq),
  .tx_frame_sync_pin_oe(tx_frame_sync_pin_oe),
  .tx_bit_clock_pin_oe(tx_bit_clock_pin_oe),
  .rx_bit_clock_pin_oe(rx_bit_clock_pin_oe)
);

//--- dv/fsp_far_end.sv
`timescale 1ns/1ps
module fsp_far_end (
  // Core clock for pacing
  input wire logic clk,
  // Port transmit side
  input wire logic tx_clk,
  input wire logic tx_fs,
  input wire logic tx_data,
  input wire logic tx_data_oe,
  // Port receive side
  output logic rx_clk,
  output logic rx_fs,
  output logic rx_data,
  output logic tx_fs_drive,
  // Captured stream
  output logic [31:0] got_word,
  output int got_bits,
  output int got_syncs
);
  initial begin
    rx_clk = 1'b0;
    rx_fs = 1'b0;
    rx_data = 1'b0;
    tx_fs_drive = 1'b0;
    got_word = 32'h0;
    got_bits = 0;
    got_syncs = 0;
  end
  // Port launches on the falling edge, so take bits on the rising one
  always @(posedge tx_clk) begin
    if (tx_data_oe === 1'b1) begin
      got_word <= {got_word[30:0], tx_data};
      got_bits <= got_bits + 1;
    end
  end
  always @(posedge tx_fs) begin
    got_syncs <= got_syncs + 1;
  end
  // Sync slot, then 32 bits MSB first; clock idles low between frames
  task automatic send_word(input logic [31:0] w);
    for (int i = -1; i < 32; i++) begin
      rx_fs = (i < 0);
      rx_data = (i < 0) ? 1'b0 : w[31-i];
      repeat (2) @(negedge clk);
      rx_clk = 1'b1;
      repeat (4) @(negedge clk);
      rx_clk = 1'b0;
      repeat (2) @(negedge clk);
    end
    rx_data = ~rx_data;
  endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] addr = 24'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, got_word;
  logic receive_irq, transmit_irq, sout, sout_oe, fsx_out, fsx_oe;
  logic txc_out, txc_oe, rxc_out, rxc_oe, far_rxc, far_fs, far_dat, far_fsd;
  logic fsx_w, txc_w, rxc_w;
  int got_bits, got_syncs, tx_irqs, rx_irqs;
  int checked = 0;
  int mismatches = 0;
  assign fsx_w = fsx_oe ? fsx_out : far_fsd;
  assign txc_w = txc_oe ? txc_out : 1'b0;
  assign rxc_w = rxc_oe ? rxc_out : far_rxc;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (transmit_irq === 1'b1) tx_irqs <= tx_irqs + 1;
    if (receive_irq === 1'b1) rx_irqs <= rx_irqs + 1;
  end
  fsp_port i_fsp_port (
    .clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .receive_irq(receive_irq),
    .transmit_irq(transmit_irq), .serial_out_pin(sout),
    .serial_out_oe(sout_oe), .serial_in_pin(far_dat),
    .tx_frame_sync_pin_in(fsx_w), .tx_frame_sync_pin_out(fsx_out),
    .tx_frame_sync_pin_oe(fsx_oe), .rx_frame_sync_pin(far_fs),
    .tx_bit_clock_pin_in(txc_w), .tx_bit_clock_pin_out(txc_out),
    .tx_bit_clock_pin_oe(txc_oe), .rx_bit_clock_pin_in(rxc_w),
    .rx_bit_clock_pin_out(rxc_out), .rx_bit_clock_pin_oe(rxc_oe)
  );
  fsp_far_end i_far (
    .clk(clk), .tx_clk(txc_w), .tx_fs(fsx_w), .tx_data(sout),
    .tx_data_oe(sout_oe), .rx_clk(far_rxc), .rx_fs(far_fs),
    .rx_data(far_dat), .tx_fs_drive(far_fsd), .got_word(got_word),
    .got_bits(got_bits), .got_syncs(got_syncs)
  );
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, output logic [31:0] d);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    d = rdata;
    rd_en = 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] v;
    rd(fsp_pkg::ADDR_GLOBAL, v);
    `CHK(v, 32'h00000002)
    rd(24'h808050, v);
    `CHK(v, 32'h00000002)
    rd(24'h808041, v);
    `CHK(v, 32'h0)
    rd(24'h808060, v);
    `CHK(v, 32'h0)
    `CHK(fsx_oe, 1'b0)
    $display("t_reset done");
  endtask
  task automatic t_flags;
    logic [31:0] v;
    wr(fsp_pkg::ADDR_GLOBAL, 32'h00FC0007);
    rd(fsp_pkg::ADDR_GLOBAL, v);
    `CHK(v, 32'h003C0006)
    `CHK(fsx_oe, 1'b1)
    wr(fsp_pkg::ADDR_GLOBAL, 32'h0);
    rd(fsp_pkg::ADDR_GLOBAL, v);
    `CHK(v, 32'h00000002)
    $display("t_flags done");
  endtask
  // Four 8-bit words back to back fill the buffer, one sync in front
  task automatic t_tx;
    logic [31:0] v;
    logic [7:0] w [4] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};
    wr(fsp_pkg::ADDR_TIM_PER, 32'h00000003);
    wr(fsp_pkg::ADDR_GLOBAL, 32'h00000444);
    tx_irqs = 0;
    @(negedge clk);
    addr = fsp_pkg::ADDR_TX_DATA;
    wr_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      wdata = {24'h0, w[i]};
      @(negedge clk);
    end
    wr_en = 1'b0;
    rd(fsp_pkg::ADDR_GLOBAL, v);
    `CHK(v[1], 1'b0)
    for (int n = 0; n < 3000 && got_bits < 32; n++) @(negedge clk);
    `CHK(got_word, 32'hA53CC35A)
    `CHK(got_syncs, 1)
    `CHK(tx_irqs > 0, 1'b1)
    rd(fsp_pkg::ADDR_GLOBAL, v);
    `CHK(v[1], 1'b1)
    $display("t_tx done");
  endtask
  task automatic t_rx;
    logic [31:0] v;
    wr(fsp_pkg::ADDR_GLOBAL, 32'h00300000);
    `CHK(rxc_oe, 1'b0)
    rx_irqs = 0;
    i_far.send_word(32'h1234ABCD);
    for (int n = 0; n < 50 && rx_irqs == 0; n++) @(negedge clk);
    `CHK(rx_irqs > 0, 1'b1)
    rd(fsp_pkg::ADDR_GLOBAL, v);
    `CHK(v[0], 1'b1)
    rd(fsp_pkg::ADDR_RX_DATA, v);
    `CHK(v, 32'h1234ABCD)
    rd(fsp_pkg::ADDR_GLOBAL, v);
    `CHK(v[0], 1'b0)
    $display("t_rx done");
  endtask
  task automatic wrap_up;
    $display("counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // A run takes a few hundred cycles; far more means a hang
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    tx_irqs = 0;
    rx_irqs = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_flags();
    t_tx();
    t_rx();
    wrap_up();
  end
endmodule
